/* core/failsafe_relay_hold_timer.sv */
`timescale 1ns/10ps
// Summary of operation
// - six relay outputs, each held by its own retriggerable timer.
// - one bus address, base 8300 hex plus four times the switch value.
// - switch bit 0 passes its address line, 1 inverts it before compare.
// - selected write captures the data byte at the strobe's rising edge.
// - D7 ignored, D6 must be set; a 0 in D0-D5 retriggers that timer.
// - each trigger keeps its relay energised about 45 seconds.
// - each relay output follows its timer's active output exactly.
// - selected read puts the six timer states on the data bus.
// - relay one to six map onto D0 to D5, 1 meaning energised.
module failsafe_relay_hold_timer #(
  parameter int RELAYS = failsafe_relay_pkg::RELAY_COUNT,
  parameter logic [failsafe_relay_pkg::HOLD_COUNT_WIDTH-1:0] HOLD_CYCLES =
    failsafe_relay_pkg::HOLD_COUNT_WIDTH'(failsafe_relay_pkg::HOLD_CYCLES)
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  input wire logic [15:0] address,
  input wire logic [7:0] dataIn,
  input wire logic readWrite,
  input wire logic busStrobe_n,
  input wire logic [3:0] addressSelectSwitch,
  output logic [7:0] dataOut,
  output logic dataOutEnable_n,
  output logic [RELAYS-1:0] relayOut
);

  localparam int SW = failsafe_relay_pkg::SWITCH_WIDTH;
  localparam int SL = failsafe_relay_pkg::SWITCH_LSB;

  // pin synchronisers
  // every bus pin is asynchronous to clock; two stages before any use
  failsafe_relay_pkg::busSample_t pinSample;
  failsafe_relay_pkg::busSample_t busMeta;
  failsafe_relay_pkg::busSample_t busSync;
  logic [SW-1:0] switchMeta;
  logic [SW-1:0] switchSync;

  assign pinSample.address = address;
  assign pinSample.data = dataIn;
  assign pinSample.readWrite = readWrite;
  assign pinSample.strobe_n = busStrobe_n;

  // strobe idles high so reset leaves the bus looking quiet
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busMeta <= '{address: '0, data: '0, readWrite: 1'b1, strobe_n: 1'b1};
    end else if (clockEnable) begin
      busMeta <= pinSample;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busSync <= '{address: '0, data: '0, readWrite: 1'b1, strobe_n: 1'b1};
    end else if (clockEnable) begin
      busSync <= busMeta;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      switchMeta <= '0;
      switchSync <= '0;
    end else if (clockEnable) begin
      switchMeta <= addressSelectSwitch;
      switchSync <= switchMeta;
    end
  end

  // address decode
  wire [SW-1:0] switchField = busSync.address[SL+SW-1:SL];
  wire [SW-1:0] conditionedField;
  wire [15:0] baseMask;
  wire [15:0] baseBits;
  wire upperMatch;
  wire fieldMatch;
  wire selected;

  // each switch bit steers an xor: 0 buffers the line, 1 inverts it
  genvar sb;
  generate
    for (sb = 0; sb < SW; sb++) begin : g_switchXor
      assign conditionedField[sb] = switchField[sb] ^ switchSync[sb];
    end
  endgenerate

  // all lines outside the switch field must equal the base exactly
  assign baseMask = ~(16'(((1 << SW) - 1) << SL));
  assign baseBits = failsafe_relay_pkg::RELAY_TRIGGER_AND_STATE;
  assign upperMatch = ((busSync.address & baseMask) == (baseBits & baseMask));
  // conditioned field zero means address = base + 4 * switch
  assign fieldMatch = (conditionedField == '0);
  assign selected = upperMatch && fieldMatch;

  // address and strobe bits resolve independently in the synchroniser,
  // so the first low strobe sample may still carry a stale address
  logic strobeLowLast;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strobeLowLast <= 1'b0;
    end else if (clockEnable) begin
      strobeLowLast <= !busSync.strobe_n;
    end
  end

  wire strobeActive = !busSync.strobe_n;
  // costs one cycle of latency on entry, none on the closing edge
  wire strobeSettled = strobeActive && strobeLowLast;
  wire writeAccess = strobeSettled && selected && !busSync.readWrite;
  wire readAccess = strobeSettled && selected && busSync.readWrite;

  // access sequencer
  failsafe_relay_pkg::busState_t state;
  failsafe_relay_pkg::busState_t next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      failsafe_relay_pkg::BUS_IDLE: begin
        if (writeAccess) begin
          next_state = failsafe_relay_pkg::BUS_WRITE;
        end else if (readAccess) begin
          next_state = failsafe_relay_pkg::BUS_READ;
        end
      end
      failsafe_relay_pkg::BUS_WRITE: begin
        if (!strobeActive) begin
          next_state = failsafe_relay_pkg::BUS_IDLE;
        end
      end
      failsafe_relay_pkg::BUS_READ: begin
        if (!strobeActive) begin
          next_state = failsafe_relay_pkg::BUS_IDLE;
        end
      end
      default: begin
        next_state = failsafe_relay_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= failsafe_relay_pkg::BUS_IDLE;
    end else if (clockEnable) begin
      state <= next_state;
    end
  end

  wire inWrite = (state == failsafe_relay_pkg::BUS_WRITE);
  wire inRead = (state == failsafe_relay_pkg::BUS_READ);

  // write capture
  // the byte is refreshed while the strobe is low, so the value used
  // is the one present just before the rising edge
  logic [7:0] capturedByte;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      capturedByte <= failsafe_relay_pkg::STATUS_RESET;
    end else if (clockEnable && writeAccess) begin
      capturedByte <= busSync.data;
    end
  end

  // rising edge of the strobe closes the write
  wire writeCommit = inWrite && !strobeActive;
  // bit seven is don't-care; without bit six the byte is not a trigger
  wire armed = capturedByte[failsafe_relay_pkg::ARM_BIT];

  logic [RELAYS-1:0] triggerPulse;

  // a zero data bit becomes a one-cycle trigger for its relay
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      triggerPulse <= '0;
    end else if (clockEnable) begin
      triggerPulse <= (writeCommit && armed) ? ~capturedByte[RELAYS-1:0] : '0;
    end
  end

  // hold timers
  logic [RELAYS-1:0] timerActive;

  genvar ri;
  generate
    for (ri = 0; ri < RELAYS; ri++) begin : g_relay
      relay_hold_timer #(
        .COUNT_WIDTH(failsafe_relay_pkg::HOLD_COUNT_WIDTH),
        .HOLD_CYCLES(HOLD_CYCLES)
      ) u_timer (
        .clock(clock),
        .reset_n(reset_n),
        .clockEnable(clockEnable),
        .trigger(triggerPulse[ri]),
        .active(timerActive[ri])
      );
    end
  endgenerate

  // relay drive is the timer output itself, no extra latency
  assign relayOut = timerActive;

  // read path
  // the host must keep each wanted relay within the retrigger window;
  // the status below is how software can see a missed retrigger
  logic [7:0] statusByte;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      statusByte <= failsafe_relay_pkg::STATUS_RESET;
    end else if (clockEnable) begin
      statusByte <= {2'b00, timerActive};
    end
  end

  assign dataOut = statusByte;
  // drive only for a selected read, released once the strobe ends
  assign dataOutEnable_n = !inRead;

endmodule

/* core/failsafe_relay_pkg.sv */
package failsafe_relay_pkg;

  localparam int RELAY_COUNT = 6;
  localparam int ADDRESS_WIDTH = 16;
  localparam int DATA_WIDTH = 8;
  localparam int SWITCH_WIDTH = 4;

  // relay positions on the data bus
  localparam int RELAY_ONE = 0;
  localparam int RELAY_TWO = 1;
  localparam int RELAY_THREE = 2;
  localparam int RELAY_FOUR = 3;
  localparam int RELAY_FIVE = 4;
  localparam int RELAY_SIX = 5;

  // the single register and its fields
  localparam logic [15:0] RELAY_TRIGGER_AND_STATE = 16'h8300;
  localparam int SWITCH_LSB = 2;
  localparam int ARM_BIT = 6;
  localparam int IGNORED_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [5:0] RELAYS_RESET = 6'h00;

  // hold timing
  localparam longint CLOCK_HZ = 40000000;
  localparam longint HOLD_TIME_MS = 45000;
  localparam longint RETRIGGER_MAX_MS = 30000;
  localparam longint HOLD_CYCLES = (HOLD_TIME_MS * CLOCK_HZ) / 1000;
  localparam int HOLD_COUNT_WIDTH = 31;

  localparam int SYNC_STAGES = 2;

  // one sample of the parallel bus pins
  typedef struct packed {
    logic [15:0] address;
    logic [7:0] data;
    logic readWrite;
    logic strobe_n;
  } busSample_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'h1,
    BUS_WRITE = 3'h2,
    BUS_READ = 3'h4
  } busState_t;

endpackage

/* core/relay_hold_timer.sv */
`timescale 1ns/10ps
module relay_hold_timer #(
  parameter int COUNT_WIDTH = failsafe_relay_pkg::HOLD_COUNT_WIDTH,
  parameter logic [COUNT_WIDTH-1:0] HOLD_CYCLES = COUNT_WIDTH'(failsafe_relay_pkg::HOLD_CYCLES)
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  input wire logic trigger,
  output logic active
);

  logic [COUNT_WIDTH-1:0] remaining;
  wire lastCycle = (remaining == COUNT_WIDTH'(1));

  // retrigger reloads the full hold period, whatever is left
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      remaining <= '0;
    end else if (clockEnable) begin
      if (trigger) begin
        remaining <= HOLD_CYCLES;
      end else if (remaining != '0) begin
        remaining <= remaining - COUNT_WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      active <= 1'b0;
    end else if (clockEnable) begin
      if (trigger) begin
        active <= 1'b1;
      end else if (lastCycle) begin
        active <= 1'b0;
      end
    end
  end

endmodule

/* verification/bus_host_model.sv */
`timescale 1ns/10ps
module bus_host_model (
  input wire logic clock,
  output logic [15:0] address,
  output logic [7:0] dataIn,
  output logic readWrite,
  output logic busStrobe_n,
  input wire logic [7:0] dataOut,
  input wire logic dataOutEnable_n
);
  initial begin
    address = 16'h0000;
    dataIn = 8'h00;
    readWrite = 1'b1;
    busStrobe_n = 1'b1;
  end
  // strobe low five clocks, high four: both beyond the three the synchroniser needs
  task automatic access(input logic rw, input logic [15:0] a, input logic [7:0] d, output logic [7:0] rd);
    @(negedge clock);
    address = a;
    readWrite = rw;
    dataIn = rw ? ~dataIn : d;
    busStrobe_n = 1'b0;
    repeat (5) @(negedge clock);
    // an undriven bus reads back as the complement of dataOut, never as a lucky match
    rd = dataOutEnable_n ? ~dataOut : dataOut;
    busStrobe_n = 1'b1;
    repeat (4) @(negedge clock);
    dataIn = ~dataIn;
    address = ~address;
  endtask
endmodule

/* verification/failsafe_relay_hold_timer_properties.sv */
`timescale 1ns/10ps
module failsafe_relay_hold_timer_properties #(
  parameter int HOLD_CYCLES = 20
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  input wire logic [15:0] address,
  input wire logic [7:0] dataIn,
  input wire logic readWrite,
  input wire logic busStrobe_n,
  input wire logic [3:0] addressSelectSwitch,
  input wire logic [7:0] dataOut,
  input wire logic dataOutEnable_n,
  input wire logic [5:0] relayOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [7:0] lastByte;
  logic [31:0] onCount;
  wire sel = address == failsafe_relay_pkg::RELAY_TRIGGER_AND_STATE + {10'h000, addressSelectSwitch, 2'b00};
  wire wrLow = sel && !readWrite && !busStrobe_n;
  wire rdLow = sel && readWrite && !busStrobe_n;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lastByte <= 8'hFF;
      onCount <= 32'h0;
    end else begin
      lastByte <= wrLow ? dataIn : lastByte;
      onCount <= relayOut[0] ? onCount + 32'h1 : 32'h0;
    end
  end
  a_reset_released: assert property ($rose(reset_n) |-> relayOut == 6'h00 && dataOutEnable_n)
    else $error("outputs active after reset");
  a_upper_bits_zero: assert property (dataOut[7:6] == 2'b00)
    else $error("status upper bits set");
  a_status_mirror: assert property (dataOut[5:0] == $past(relayOut))
    else $error("status differs from relays");
  a_write_triggers: assert property (wrLow [*3] ##1 (busStrobe_n && lastByte[6])
    |-> ##[2:5] (relayOut | lastByte[5:0]) == 6'h3F)
    else $error("write did not energise relays");
  a_arm_clear_ignored: assert property (wrLow [*3] ##1 (busStrobe_n && !lastByte[6])
    |-> ((relayOut & ~$past(relayOut)) == 6'h00) [*6])
    else $error("write without arm bit acted");
  a_hold_not_short: assert property ($fell(relayOut[0]) |-> onCount >= HOLD_CYCLES - 1)
    else $error("relay released early");
  a_read_drives: assert property (rdLow [*5] |-> !dataOutEnable_n)
    else $error("read not driven");
  a_no_stray_drive: assert property ((!rdLow) [*4] |-> dataOutEnable_n)
    else $error("bus driven without read");
  c_write: cover property (wrLow [*3] ##1 busStrobe_n);
  c_read: cover property (!dataOutEnable_n);
  c_release: cover property ($fell(relayOut[0]));
endmodule

/* verification/failsafe_relay_hold_timer_tb_top.sv */
`timescale 1ns/10ps
module failsafe_relay_hold_timer_tb_top;
  localparam int HOLD = 200;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic clockEnable = 1'b1;
  logic [3:0] addressSelectSwitch = 4'h0;
  logic [15:0] address;
  logic [7:0] dataIn, dataOut, rd;
  logic readWrite, busStrobe_n, dataOutEnable_n;
  logic [5:0] relayOut;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int trig [6];
  always #12.5 clock = ~clock;
  failsafe_relay_hold_timer #(.HOLD_CYCLES(31'(HOLD))) i_dut (.clock, .reset_n, .clockEnable, .address,
    .dataIn, .readWrite, .busStrobe_n, .addressSelectSwitch, .dataOut, .dataOutEnable_n, .relayOut);
  bus_host_model i_host (.clock, .address, .dataIn, .readWrite, .busStrobe_n, .dataOut, .dataOutEnable_n);
  task automatic results();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  function automatic logic [15:0] base();
    return failsafe_relay_pkg::RELAY_TRIGGER_AND_STATE + {10'h000, addressSelectSwitch, 2'b00};
  endfunction
  // {known, on}: relays close to a switching moment are left out
  function automatic logic [11:0] predict(int now);
    logic [11:0] p = 12'h000;
    for (int i = 0; i < 6; i++) begin
      p[i] = now - trig[i] <= HOLD;
      p[i + 6] = (now - trig[i] >= 8 && now - trig[i] <= HOLD) || now - trig[i] > HOLD + 10;
    end
    return p;
  endfunction
  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    i_host.access(1'b0, a, d, rd);
    for (int i = 0; i < 6; i++) begin
      if (a == base() && d[6] && !d[i]) trig[i] = cyc - 4;
    end
  endtask
  task automatic rdchk();
    logic [11:0] p;
    i_host.access(1'b1, base(), 8'h00, rd);
    p = predict(cyc - 4);
    check("status", {2'b00, p[5:0] & p[11:6]}, rd & {2'b11, p[11:6]});
    p = predict(cyc);
    check("relays", {2'b00, p[5:0] & p[11:6]}, {2'b00, relayOut & p[11:6]});
  endtask
  initial begin
    logic [7:0] corner [4] = '{8'h00, 8'h7B, 8'hFF, 8'hC0};
    logic [15:0] a;
    for (int i = 0; i < 6; i++) trig[i] = -100000;
    void'($urandom(32'h749AF885));
    addressSelectSwitch = 4'($urandom_range(0, 9));
    repeat (5) @(posedge clock);
    @(negedge clock);
    reset_n = 1'b1;
    rdchk();
    foreach (corner[k]) begin
      wr(base(), corner[k]);
      rdchk();
    end
    repeat (12) begin
      a = ($urandom_range(0, 3) == 0) ? base() ^ (16'h0004 << $urandom_range(0, 3)) : base();
      wr(a, 8'($urandom));
      rdchk();
      repeat ($urandom_range(0, 30)) @(negedge clock);
    end
    repeat (4) begin
      wr(base(), 8'h7E);
      repeat (HOLD / 2) @(negedge clock);
      rdchk();
    end
    // a frozen block must stretch the hold by exactly the frozen time
    clockEnable = 1'b0;
    repeat (HOLD) @(negedge clock);
    clockEnable = 1'b1;
    for (int i = 0; i < 6; i++) trig[i] += HOLD;
    rdchk();
    repeat (HOLD + 20) @(negedge clock);
    rdchk();
    wr(base(), 8'h40);
    reset_n = 1'b0;
    for (int i = 0; i < 6; i++) trig[i] = -100000;
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    rdchk();
    results();
  end
endmodule
bind failsafe_relay_hold_timer failsafe_relay_hold_timer_properties #(.HOLD_CYCLES(HOLD_CYCLES)) i_props (
  .clock, .reset_n, .clockEnable, .address, .dataIn, .readWrite, .busStrobe_n, .addressSelectSwitch,
  .dataOut, .dataOutEnable_n, .relayOut);
